// ==== ptwg_pkg.sv ====
// Package: register map, fields and timing constants of the trigger waveform generator
package ptwg_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] PTWG_CTRL1_OFS     = 12'h538;
  localparam logic [11:0] PTWG_CYCW_OFS      = 12'h53c;
  localparam logic [11:0] PTWG_CNTPAT_OFS    = 12'h540;
  localparam logic [11:0] PTWG_CHAIN_OFS     = 12'h544;
  localparam logic [11:0] PTWG_PWIDTH_OFS    = 12'h548;
  localparam logic [11:0] PTWG_INDEX_OFS     = 12'h534;
  localparam logic [11:0] PTWG_STATUS_OFS    = 12'h54c;

  // Control fields (own control register), pulse width mask and count field position
  localparam int PTWG_EN_BIT      = 31;
  localparam int PTWG_TAIL_BIT    = 30;
  localparam int PTWG_CASC_BIT    = 29;
  localparam int PTWG_SOFTCLR_BIT = 28;
  localparam int PTWG_NOW_BIT     = 25;
  localparam int PTWG_EDGE_BIT    = 23;
  localparam int PTWG_PAT_LSB     = 20;
  localparam int PTWG_ITER_LSB    = 0;
  localparam logic [31:0] PTWG_CTRL1_MASK  = 32'he2f0ffff;
  localparam logic [31:0] PTWG_PWIDTH_MASK = 32'h00ffffff;
  localparam int PTWG_CNT_LSB     = 16;

  // Reset values
  localparam logic [31:0] PTWG_RST_VAL = 32'h00000000;

  // Timing
  localparam int PTWG_CLK_PERIOD_NS = 8;
  localparam int PTWG_PW_UNIT_NS    = 8;
  localparam int PTWG_MAX_FREQ_KHZ  = 12500;
  localparam int PTWG_MIN_HALF_NS   = 1000000 / (2 * PTWG_MAX_FREQ_KHZ);
  localparam int PTWG_MIN_HALF_CYC  =
    (PTWG_MIN_HALF_NS + PTWG_CLK_PERIOD_NS - 1) / PTWG_CLK_PERIOD_NS;

  // Waveform selections and sequencer states
  typedef enum logic [2:0] {
    PTWG_PAT_FALL   = 3'b000,
    PTWG_PAT_RISE   = 3'b001,
    PTWG_PAT_NPULSE = 3'b010,
    PTWG_PAT_PPULSE = 3'b011,
    PTWG_PAT_NPER   = 3'b100,
    PTWG_PAT_PPER   = 3'b101,
    PTWG_PAT_SERIAL = 3'b110,
    PTWG_PAT_RSVD   = 3'b111
  } ptwg_pat_e;

  typedef enum logic [1:0] {
    PTWG_ST_IDLE  = 2'b00,
    PTWG_ST_ACT   = 2'b01,
    PTWG_ST_REST  = 2'b10,
    PTWG_ST_DONE  = 2'b11
  } ptwg_state_e;

endpackage : ptwg_pkg

// ==== ptwg_top.sv ====
// Trigger output waveform generator with banked registers
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Waveform starts only when enabled and system time has reached target time.
// RULE2: Code 000 drives high idle to low, stays low.
// RULE3: Code 001 gives one rising edge, output stays high.
// RULE4: Codes 010/011 give one low or high pulse of programmed width.
// RULE5: Codes 100/101 periodic with programmed phase width; zero count means endless.
// RULE6: Code 110 shifts 16-bit pattern MSB first, looped; 111 reserved.
// RULE7: Output never toggles faster than 12.5 MHz whatever widths are set.
// RULE8: Cascade tail repeats pattern iteration count plus one times.
// RULE9: Without a tail unit, iteration count ignored, pattern repeats forever.
// RULE10: Cycle or bit width counted in one nanosecond units.
// RULE11: Upper sixteen bits hold cycle or bit count; zero is unlimited.
// RULE12: Lower sixteen bits of count register hold serial bit pattern.
// RULE13: Unit registers banked, bank chosen by two-bit unit index pointer.
// RULE14: Cascade adds iteration cycle time to target time for next trigger.
// RULE15: Pulse width field counted in 8 ns units.
// RULE16: Eight-bit extension forms pulse width bits 23:16.
// RULE17: Pulse width register serves PPS width unit 2, delay compensation unit 1.
// RULE18: Trigger-now fires at once when target already passed.
// RULE19: Edge select launches output on negative or positive clock edge.
// RULE20: Endless cascade loop stops by software clear bit, by clearing enable or by reset.
// RULE21: Reset or disabled holds output at pattern idle level, no transitions.
// RULE22: Reserved bits read zero and ignore writes.
module ptwg_top
  import ptwg_pkg::*;
#(
  parameter int UNITS = 4
)(
  // Clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  // Register port
  input  wire logic [11:0] ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  // Time base
  input  wire logic [63:0] SYS_TIME_NS_IN,
  input  wire logic [63:0] TARGET_TIME_NS_IN,
  // Trigger pins, cascade next target and delay compensation
  output logic      [UNITS-1:0] TRIG_OUT,
  output logic      [63:0] NEXT_TARGET_NS_OUT,
  output logic      [31:0] DELAY_COMP_OUT
);

  initial
  begin
    if (UNITS != 4)
      $error("ptwg_top: UNITS must be 4 for a two-bit index pointer");
  end

  // Register file
  logic [1:0]  index_q;
  logic [31:0] ctrl_q   [UNITS];
  logic [31:0] cycw_q   [UNITS];
  logic [31:0] cntpat_q [UNITS];
  logic [31:0] chain_q  [UNITS];
  logic [31:0] pwidth_q [UNITS];
  logic [31:0] rdata_q;
  logic [UNITS-1:0] busy;

  wire hit_idx = ADDR_IN == PTWG_INDEX_OFS;
  wire hit_ctl = ADDR_IN == PTWG_CTRL1_OFS;
  wire hit_cyc = ADDR_IN == PTWG_CYCW_OFS;
  wire hit_cnt = ADDR_IN == PTWG_CNTPAT_OFS;
  wire hit_chn = ADDR_IN == PTWG_CHAIN_OFS;
  wire hit_pw  = ADDR_IN == PTWG_PWIDTH_OFS;
  wire hit_st  = ADDR_IN == PTWG_STATUS_OFS;
  wire no_tail = ~|{ctrl_q[0][PTWG_TAIL_BIT], ctrl_q[1][PTWG_TAIL_BIT],
                    ctrl_q[2][PTWG_TAIL_BIT], ctrl_q[3][PTWG_TAIL_BIT]};

  // Read mux, banked by index [RULE13] [RULE22]
  wire [31:0] rd_mux =
    hit_idx ? {30'h0, index_q} :
    hit_ctl ? ctrl_q[index_q] :
    hit_cyc ? cycw_q[index_q] :
    hit_cnt ? cntpat_q[index_q] :
    hit_chn ? chain_q[index_q] :
    hit_pw  ? pwidth_q[index_q] :
    hit_st  ? {28'h0, busy} : 32'h0;

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      rdata_q <= PTWG_RST_VAL;
    else if (RD_IN)
      rdata_q <= rd_mux;
    else
      rdata_q <= 32'h0;
  end
  assign RDATA_OUT = rdata_q;

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      index_q <= 2'h0;
    else if (WR_IN && hit_idx)
      index_q <= WDATA_IN[1:0];
  end

  // Cascade next target time [RULE14]
  logic [63:0] next_q;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      next_q <= 64'h0;
    else if (ctrl_q[0][PTWG_CASC_BIT] && busy[0])
      next_q <= TARGET_TIME_NS_IN + {32'h0, chain_q[0]};
  end
  assign NEXT_TARGET_NS_OUT = next_q;
  assign DELAY_COMP_OUT     = {8'h0, pwidth_q[1][23:0]}; // [RULE17]

  genvar u;
  generate
    for (u = 0; u < UNITS; u++)
    begin : g_unit
      ptwg_state_e st_q;
      logic [31:0] tmr_q;
      logic [15:0] cnt_q;
      logic [16:0] iter_q;
      logic [3:0]  bit_q;
      logic        lvl_q;
      logic        neg_q;
      logic        fired_q;
      wire         wr_sel = WR_IN && (index_q == u);
      wire [31:0]  c     = ctrl_q[u];
      wire [2:0]   pat   = c[PTWG_PAT_LSB +: 3];
      wire         en    = c[PTWG_EN_BIT];
      wire         sclr  = wr_sel && hit_ctl && WDATA_IN[PTWG_SOFTCLR_BIT];
      wire [15:0]  cnt_f = cntpat_q[u][PTWG_CNT_LSB +: 16]; // [RULE11]
      wire [15:0]  patt  = cntpat_q[u][15:0]; // [RULE12]
      // Widths in clock cycles, clamped to the frequency limit [RULE7]
      wire [31:0]  ns_cyc = cycw_q[u] / PTWG_CLK_PERIOD_NS; // [RULE10]
      wire [31:0]  pw_cyc = {8'h0, pwidth_q[u][23:0]}; // [RULE15] [RULE16]
      wire [31:0]  min_c  = 32'(PTWG_MIN_HALF_CYC);
      wire [31:0]  w_cyc  = (ns_cyc < min_c) ? min_c : ns_cyc;
      wire [31:0]  p_cyc  = (pw_cyc < min_c) ? min_c : pw_cyc;
      // Rising-edge pattern idles low so its single edge is visible [RULE3]
      wire         idle_hi = pat != PTWG_PAT_PPULSE && pat != PTWG_PAT_PPER &&
                             pat != PTWG_PAT_RISE;
      wire         due = (SYS_TIME_NS_IN >= TARGET_TIME_NS_IN) &&
                         (c[PTWG_NOW_BIT] || !fired_q); // [RULE1] [RULE18]
      wire         act_lvl = (pat == PTWG_PAT_PPULSE || pat == PTWG_PAT_PPER);
      wire         endless = no_tail || !c[PTWG_CASC_BIT] || !c[PTWG_TAIL_BIT];

      // Bank registers [RULE13] [RULE22]
      always_ff @(posedge CORE_CLK_IN)
      begin
        if (RST_IN)
        begin
          ctrl_q[u]   <= PTWG_RST_VAL;
          cycw_q[u]   <= PTWG_RST_VAL;
          cntpat_q[u] <= PTWG_RST_VAL;
          chain_q[u]  <= PTWG_RST_VAL;
          pwidth_q[u] <= PTWG_RST_VAL;
        end
        else if (wr_sel)
        begin
          if (hit_ctl) ctrl_q[u]   <= WDATA_IN & PTWG_CTRL1_MASK & ~32'h10000000;
          if (hit_cyc) cycw_q[u]   <= WDATA_IN;
          if (hit_cnt) cntpat_q[u] <= WDATA_IN;
          if (hit_chn) chain_q[u]  <= WDATA_IN;
          if (hit_pw)  pwidth_q[u] <= WDATA_IN & PTWG_PWIDTH_MASK;
        end
      end

      // Waveform sequencer
      always_ff @(posedge CORE_CLK_IN)
      begin
        if (RST_IN || !en || sclr) // [RULE20] [RULE21]
        begin
          st_q    <= PTWG_ST_IDLE;
          tmr_q   <= 32'h0;
          cnt_q   <= 16'h0;
          iter_q  <= 17'h0;
          bit_q   <= 4'hf;
          fired_q <= 1'b0;
          lvl_q   <= RST_IN ? 1'b1 : idle_hi;
        end
        else
        begin
          case (st_q)
            PTWG_ST_IDLE:
            begin
              lvl_q <= idle_hi;
              if (due && pat != PTWG_PAT_RSVD) // [RULE6]
              begin
                fired_q <= 1'b1;
                st_q    <= PTWG_ST_ACT;
                bit_q   <= 4'hf;
                cnt_q   <= 16'h0;
                iter_q  <= 17'h0;
                case (pat)
                  PTWG_PAT_FALL: begin lvl_q <= 1'b0; st_q <= PTWG_ST_DONE; end // [RULE2]
                  PTWG_PAT_RISE: begin lvl_q <= 1'b1; st_q <= PTWG_ST_DONE; end // [RULE3]
                  PTWG_PAT_SERIAL: begin lvl_q <= patt[15]; tmr_q <= w_cyc; end
                  PTWG_PAT_NPER, PTWG_PAT_PPER: begin lvl_q <= act_lvl; tmr_q <= p_cyc; end
                  default: begin lvl_q <= act_lvl; tmr_q <= p_cyc; end // [RULE4]
                endcase
              end
            end
            PTWG_ST_ACT:
            begin
              if (tmr_q > 32'h1)
                tmr_q <= tmr_q - 32'h1;
              else if (pat == PTWG_PAT_SERIAL)
              begin
                // Shift MSB first, count bits and loop [RULE6]
                if (cnt_f != 16'h0 && cnt_q + 16'h1 == cnt_f)
                  st_q <= PTWG_ST_DONE;
                else if (bit_q == 4'h0 && !endless &&
                         iter_q == {1'b0, c[15:0]}) // [RULE8] [RULE9]
                  st_q <= PTWG_ST_DONE;
                else
                begin
                  cnt_q <= cnt_q + 16'h1;
                  if (bit_q == 4'h0) iter_q <= iter_q + 17'h1;
                  bit_q <= bit_q - 4'h1;
                  lvl_q <= patt[4'(bit_q - 4'h1)];
                  tmr_q <= w_cyc;
                end
              end
              else if (pat == PTWG_PAT_NPER || pat == PTWG_PAT_PPER)
              begin
                lvl_q <= ~act_lvl;
                tmr_q <= (w_cyc > p_cyc + min_c) ? w_cyc - p_cyc : min_c;
                st_q  <= PTWG_ST_REST;
              end
              else
              begin
                lvl_q <= ~act_lvl; // [RULE4]
                st_q  <= PTWG_ST_DONE;
              end
            end
            PTWG_ST_REST:
            begin
              if (tmr_q > 32'h1)
                tmr_q <= tmr_q - 32'h1;
              else if (cnt_f != 16'h0 && cnt_q + 16'h1 == cnt_f) // [RULE5]
                st_q <= PTWG_ST_DONE;
              else
              begin
                cnt_q <= cnt_q + 16'h1;
                lvl_q <= act_lvl;
                tmr_q <= p_cyc;
                st_q  <= PTWG_ST_ACT;
              end
            end
            PTWG_ST_DONE:
            begin
              if (pat == PTWG_PAT_SERIAL || pat == PTWG_PAT_NPER ||
                  pat == PTWG_PAT_PPER)
                lvl_q <= idle_hi;
            end
            default: st_q <= PTWG_ST_IDLE;
          endcase
        end
      end

      // Optional launch on falling clock edge [RULE19]
      always_ff @(negedge CORE_CLK_IN)
      begin
        if (RST_IN)
          neg_q <= 1'b1;
        else
          neg_q <= lvl_q;
      end
      assign TRIG_OUT[u] = c[PTWG_EDGE_BIT] ? neg_q : lvl_q;
      assign busy[u]     = st_q == PTWG_ST_ACT || st_q == PTWG_ST_REST;
    end
  endgenerate

endmodule : ptwg_top

// ==== ptwg_properties.sv ====
// Checker: port-level properties of the trigger waveform generator
`timescale 1ns/1ps
module ptwg_chk
  import ptwg_pkg::*;
#(
  parameter int UNITS = 4
)(
  // Watched ports
  input wire logic             CORE_CLK_IN,
  input wire logic             RST_IN,
  input wire logic [11:0]      ADDR_IN,
  input wire logic [31:0]      WDATA_IN,
  input wire logic             WR_IN,
  input wire logic             RD_IN,
  input wire logic [31:0]      RDATA_OUT,
  input wire logic [63:0]      SYS_TIME_NS_IN,
  input wire logic [63:0]      TARGET_TIME_NS_IN,
  input wire logic [UNITS-1:0] TRIG_OUT,
  input wire logic [31:0]      DELAY_COMP_OUT
);
  logic [1:0]  idx_q;
  logic [23:0] comp_q;
  logic        wait_q;
  // Shadows of index, unit 1 width, not-yet-due
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      idx_q  <= 2'h0;
      comp_q <= 24'h0;
      wait_q <= 1'b1;
    end
    else
    begin
      if (WR_IN && ADDR_IN == PTWG_INDEX_OFS) idx_q <= WDATA_IN[1:0];
      if (WR_IN && ADDR_IN == PTWG_PWIDTH_OFS && idx_q == 2'h1) comp_q <= WDATA_IN[23:0];
      if (SYS_TIME_NS_IN >= TARGET_TIME_NS_IN) wait_q <= 1'b0;
    end
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  a_rdata_rest_zero: assert property (
    !$past(RD_IN) |-> RDATA_OUT == 32'h0) else $error("read data outside read slot");
  a_unmapped_read: assert property (
    $past(RD_IN) && $past(ADDR_IN[11:8]) != 4'h5 |-> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_reserved_zero: assert property (
    $past(RD_IN) && $past(ADDR_IN) == PTWG_CTRL1_OFS |-> (RDATA_OUT & ~PTWG_CTRL1_MASK) == 32'h0)
    else $error("control reserved bits set");
  a_pw_reserved_zero: assert property (
    $past(RD_IN) && $past(ADDR_IN) == PTWG_PWIDTH_OFS |-> RDATA_OUT[31:24] == 8'h0)
    else $error("width reserved bits set");
  a_index_readback: assert property (
    $past(RD_IN) && $past(ADDR_IN) == PTWG_INDEX_OFS |-> RDATA_OUT == {30'h0, $past(idx_q)})
    else $error("index readback wrong");
  a_delay_comp_track: assert property (
    DELAY_COMP_OUT == {8'h0, comp_q}) else $error("delay compensation wrong");
  a_no_early_fire: assert property (
    wait_q |-> $stable(TRIG_OUT)) else $error("output moved before due time");
  a_min_half_period: assert property (
    $changed(TRIG_OUT[0]) |=> $stable(TRIG_OUT[0]) [*4]) else $error("output toggles too fast");
endmodule : ptwg_chk

bind ptwg_top ptwg_chk #(.UNITS(UNITS)) u_chk (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SYS_TIME_NS_IN(SYS_TIME_NS_IN),
  .TARGET_TIME_NS_IN(TARGET_TIME_NS_IN), .TRIG_OUT(TRIG_OUT), .DELAY_COMP_OUT(DELAY_COMP_OUT));

// ==== ptwg_receiver.sv ====
// Receiver model: tallies low cycles and falling edges on one trigger pin
`timescale 1ns/1ps
module ptwg_receiver (
  // Clock, clear and pin
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic        pin_in,
  // Tallies
  output logic      [15:0] low_out,
  output logic      [15:0] fall_out
);
  logic last_q;
  always_ff @(posedge clk_in)
  begin
    last_q <= pin_in;
    if (clr_in)
    begin
      low_out  <= 16'h0;
      fall_out <= 16'h0;
    end
    else
    begin
      if (!pin_in) low_out <= low_out + 16'h1;
      if (last_q && !pin_in) fall_out <= fall_out + 16'h1;
    end
  end
endmodule : ptwg_receiver

// ==== ptwg_top_test.sv ====
// Testbench: register and waveform checks of the trigger generator
`timescale 1ns/1ps
module ptwg_top_test import ptwg_pkg::*;;
  logic        clk, rst, wr, rd, clr;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, comp;
  logic [63:0] sys, tgt, next_t;
  logic [3:0]  trig;
  logic [15:0] low, fall;
  int          fail_count = 0;
  int          check_count = 0;
  ptwg_top #(.UNITS(4)) dut (.CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SYS_TIME_NS_IN(sys), .TARGET_TIME_NS_IN(tgt),
    .TRIG_OUT(trig), .NEXT_TARGET_NS_OUT(next_t), .DELAY_COMP_OUT(comp));
  ptwg_receiver u_rx (.clk_in(clk), .clr_in(clr), .pin_in(trig[0]), .low_out(low),
    .fall_out(fall));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wrt(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrt
  task automatic rdc(logic [11:0] a, logic [31:0] e, string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, e, rdata);
  endtask : rdc
  task automatic fire(logic [31:0] ctrl);
    wrt(PTWG_CTRL1_OFS, ctrl);
    @(posedge clk);
    clr <= 1'b0;
    sys <= 64'd2000;
  endtask : fire
  task automatic stop;
    wrt(PTWG_CTRL1_OFS, 32'h0);
    @(posedge clk);
    sys <= 64'd0;
    clr <= 1'b1;
  endtask : stop
  task automatic t_regs;
    rdc(PTWG_CYCW_OFS, 32'h0, "cycle width reset");
    rdc(PTWG_CNTPAT_OFS, 32'h0, "count reset");
    rdc(PTWG_CHAIN_OFS, 32'h0, "chain time reset");
    wrt(PTWG_INDEX_OFS, 32'h1);
    wrt(PTWG_CYCW_OFS, 32'h11);
    wrt(PTWG_PWIDTH_OFS, 32'hffffffff);
    #1;
    chk("delay comp", 64'h00ffffff, comp);
    rdc(PTWG_PWIDTH_OFS, 32'h00ffffff, "width unit 1");
    rdc(PTWG_INDEX_OFS, 32'h1, "index");
    wrt(PTWG_INDEX_OFS, 32'h0);
    rdc(PTWG_CYCW_OFS, 32'h0, "cycle width bank 0");
    rdc(12'h7fc, 32'h0, "unmapped");
    wrt(PTWG_CTRL1_OFS, 32'h1f0fffff);
    rdc(PTWG_CTRL1_OFS, 32'h0200ffff, "control reserved");
    wrt(PTWG_CTRL1_OFS, 32'h0);
  endtask : t_regs
  task automatic t_fall;
    fire(32'h80000000);
    tick(20);
    chk("fall level", 64'h0, trig[0]);
    chk("fall edges", 64'h1, fall);
    stop;
  endtask : t_fall
  task automatic t_rise;
    wrt(PTWG_CTRL1_OFS, 32'h00100000);
    tick(8);
    chk("rise idle", 64'h0, trig[0]);
    fire(32'h80100000);
    tick(10);
    chk("rise level", 64'h1, trig[0]);
    stop;
  endtask : t_rise
  task automatic t_pulse;
    wrt(PTWG_PWIDTH_OFS, 32'ha);
    fire(32'h80200000);
    tick(30);
    chk("pulse low", 64'ha, low);
    chk("pulse edges", 64'h1, fall);
    stop;
  endtask : t_pulse
  task automatic t_period;
    wrt(PTWG_CYCW_OFS, 32'h50);
    wrt(PTWG_PWIDTH_OFS, 32'h5);
    wrt(PTWG_CNTPAT_OFS, 32'h00030000);
    fire(32'h80400000);
    tick(60);
    chk("periods", 64'h3, fall);
    chk("period low", 64'hf, low);
    stop;
  endtask : t_period
  task automatic t_serial;
    logic [15:0] pat;
    pat = 16'h5a0f;
    wrt(PTWG_CYCW_OFS, 32'h28);
    wrt(PTWG_CNTPAT_OFS, {16'h8, pat});
    fire(32'h80600000);
    for (int i = 0; i < 20 && trig[0] !== 1'b0; i++) tick(1);
    tick(2);
    for (int i = 0; i < 8; i++)
    begin
      chk("serial bit", 64'(pat[15 - i]), trig[0]);
      tick(5);
    end
    tick(20);
    stop;
  endtask : t_serial
  task automatic t_cascade;
    wrt(PTWG_CHAIN_OFS, 32'h320);
    wrt(PTWG_CNTPAT_OFS, 32'h00007fff);
    fire(32'he0600001);
    tick(40);
    chk("next target", 64'd1800, next_t);
    tick(200);
    chk("repetitions", 64'h2, fall);
    stop;
  endtask : t_cascade
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial
  begin
    tick(4000);
    fail_count++;
    conclude;
  end
  initial
  begin
    {rst, clr, wr, rd, addr, wdata} = {2'b11, 2'b00, 12'h0, 32'h0};
    sys = 64'd0;
    tgt = 64'd1000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_fall;
    t_rise;
    t_pulse;
    t_period;
    t_serial;
    t_cascade;
    conclude;
  end
endmodule : ptwg_top_test
